/* mtw_acc_dec.sv */
`timescale 1ns/1ps
module mtw_acc_dec (
  input  wire logic [2:0] acc_in,
  output logic      [5:0] prot_out
);
  always_comb begin
    unique case (acc_in)
      mtw_pkg::ACC_RO:    prot_out = mtw_pkg::PROT_RO;
      mtw_pkg::ACC_RW:    prot_out = mtw_pkg::PROT_RW;
      mtw_pkg::ACC_RX:    prot_out = mtw_pkg::PROT_RX;
      mtw_pkg::ACC_RWX:   prot_out = mtw_pkg::PROT_RWX;
      mtw_pkg::ACC_XO:    prot_out = mtw_pkg::PROT_XO;
      mtw_pkg::ACC_UR_SX: prot_out = mtw_pkg::PROT_UR_SX;
      mtw_pkg::ACC_SRX:   prot_out = mtw_pkg::PROT_SRX;
      mtw_pkg::ACC_SRWX:  prot_out = mtw_pkg::PROT_SRWX;
    endcase
  end
endmodule : mtw_acc_dec

/* mtw_mem_model.sv */
`timescale 1ns/1ps
module mtw_mem_model (
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic [30:0] addr_in,
  output logic             ack_out,
  output logic      [31:0] rdata_out
);
  logic [31:0] mem [int];
  int          wait_n = 0;
  int          n_rd   = 0;
  int          cnt    = 0;
  initial begin
    ack_out   = 1'b0;
    rdata_out = 32'hA5A5_A5A5;
  end
  // Ack after wait_n cycles, data scrambled outside ack
  always @(posedge clk_in) begin
    #1;
    if (req_in === 1'b1 && ack_out === 1'b0 && cnt >= wait_n) begin
      ack_out   = 1'b1;
      rdata_out = mem.exists(int'(addr_in)) ? mem[int'(addr_in)] : 32'h0000_0000;
      n_rd++;
      cnt = 0;
    end else begin
      ack_out   = 1'b0;
      rdata_out = ~rdata_out;
      cnt = (req_in === 1'b1) ? cnt + 1 : 0;
    end
  end
endmodule : mtw_mem_model

/* mtw_pkg.sv */
package mtw_pkg;
  // Widths
  localparam int VA_W   = 32;
  localparam int PA_W   = 31;
  localparam int CTX_W  = 6;
  localparam int PTR_W  = 23;
  localparam int PPN_W  = 19;
  localparam int TAG_W  = 20;
  localparam int SBA_W  = 28;
  localparam int PROT_W = 6;
  localparam int IDX_W  = 8;
  // Table entry fields
  localparam logic [1:0] ET_INVALID   = 2'h0;
  localparam logic [1:0] ET_PTP       = 2'h1;
  localparam logic [1:0] ET_PTE       = 2'h2;
  localparam logic [1:0] ET_RSVD      = 2'h3;
  localparam int         ET_LSB       = 0;
  localparam int         ACC_LSB      = 2;
  localparam int         PTR_LSB      = 4;
  localparam int         PPN_LSB      = 8;
  localparam int         MOD_BIT      = 6;
  localparam int         IO_VALID_BIT = 1;
  localparam int         IO_WR_BIT    = 2;
  // Access permission codes
  localparam logic [2:0] ACC_RO    = 3'h0;
  localparam logic [2:0] ACC_RW    = 3'h1;
  localparam logic [2:0] ACC_RX    = 3'h2;
  localparam logic [2:0] ACC_RWX   = 3'h3;
  localparam logic [2:0] ACC_XO    = 3'h4;
  localparam logic [2:0] ACC_UR_SX = 3'h5;
  localparam logic [2:0] ACC_SRX   = 3'h6;
  localparam logic [2:0] ACC_SRWX  = 3'h7;
  // Decoded protection, order {user r,w,x, supervisor r,w,x}
  localparam logic [5:0] PROT_RO    = 6'h24;
  localparam logic [5:0] PROT_RW    = 6'h36;
  localparam logic [5:0] PROT_RX    = 6'h2d;
  localparam logic [5:0] PROT_RWX   = 6'h3f;
  localparam logic [5:0] PROT_XO    = 6'h09;
  localparam logic [5:0] PROT_UR_SX = 6'h21;
  localparam logic [5:0] PROT_SRX   = 6'h05;
  localparam logic [5:0] PROT_SRWX  = 6'h07;
  // TLB level field
  localparam logic [2:0] LVL_NONE = 3'h0;
  localparam logic [2:0] LVL_1    = 3'h4;
  localparam logic [2:0] LVL_12   = 3'h6;
  localparam logic [2:0] LVL_123  = 3'h7;
  // Walk position
  localparam logic [2:0] WL_CTX = 3'h0;
  localparam logic [2:0] WL_L1  = 3'h1;
  localparam logic [2:0] WL_L2  = 3'h2;
  localparam logic [2:0] WL_L3  = 3'h3;
  localparam logic [2:0] WL_IO  = 3'h4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOOK = 3'b010,
    ST_MEM  = 3'b100
  } mtw_state_e;
endpackage : mtw_pkg

/* mtw_tlb_walk.sv */
`timescale 1ns/1ps
// Overview of operation
// - Decode 3-bit access permission code into user and supervisor rights.
// - Entry type bits 1:0: invalid, next-table pointer, translation, reserved.
// - Pointer entry bits 26:4 give next table address; others reserved zero.
// - Cache pointer entries fetched from levels 1 and 2 in the TLB; later walks may evict them.
// - I/O entry bits 26:8 supply physical address bits 30:12.
// - I/O entry valid only with bit 1; writes need bit 2 set.
// - Compare address and context with every TLB entry in parallel.
// - On hit, physical page from entry, address bits 11:0 pass through.
// - Check protection on every hit; violations raise a memory exception.
// - On a miss, walk the tables in memory automatically.
// - IU walk starts in context table, indexed by context number, or at a cached level 2 or 3 pointer; direct access reads the I/O table.
// - Levels 1, 2, 3 indexed by successive address fields; level 3 maps 4 KB.
// - A fetched pointer entry continues the walk one level lower; a pointer entry fetched at level 3 gives a walk fault.
// - A fetched translation entry stops the walk and, below the context table, loads the TLB.
// - No translation found gives a synchronous fault to the integer unit.
// - Region size follows terminating level: 4 GB, 16 MB, 256 KB, 4 KB.
// - Level 2 termination: bits 31:18 index, bits 17:0 offset.
// - Translate the direct-access address and drive it onto the bus address.
// - Per-entry level field selects tag bits; its top bit marks valid.
// - Entry context tag compared with the 6-bit context number.
// - Supervisor bit set makes matching ignore the context.
// - Set the entry modified bit when the page is written.
module mtw_tlb_walk #(
  parameter int TLB_N    = 16,
  parameter int IO_IDX_W = 8
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic [mtw_pkg::CTX_W-1:0]     ctx_in,
  input  wire logic [mtw_pkg::PTR_W-1:0]     ctx_table_ptr_in,
  input  wire logic [mtw_pkg::PTR_W-1:0]     io_table_ptr_in,
  input  wire logic                          tlb_flush_in,
  input  wire logic                          iu_req_in,
  input  wire logic [mtw_pkg::VA_W-1:0]      iu_va_in,
  input  wire logic                          iu_write_in,
  input  wire logic                          iu_exec_in,
  input  wire logic                          iu_super_in,
  output logic                               iu_ack_out,
  output logic      [mtw_pkg::PA_W-1:0]      iu_pa_out,
  output logic                               iu_prot_fault_out,
  output logic                               iu_walk_fault_out,
  input  wire logic                          dva_req_in,
  input  wire logic [mtw_pkg::VA_W-1:0]      dva_va_in,
  input  wire logic                          dva_write_in,
  output logic                               dva_ack_out,
  output logic      [mtw_pkg::SBA_W-1:0]     dva_pa_out,
  output logic                               dva_fault_out,
  output logic                               mem_req_out,
  output logic      [mtw_pkg::PA_W-1:0]      mem_addr_out,
  input  wire logic                          mem_ack_in,
  input  wire logic [31:0]                   mem_rdata_in,
  output logic                               walk_busy_out
);
  localparam int         IW      = $clog2(TLB_N);
  localparam logic [7:0] IO_MASK = 8'((2 ** IO_IDX_W) - 1);

  if (TLB_N < 2 || (TLB_N & (TLB_N - 1)) != 0 || IO_IDX_W < 1 || IO_IDX_W > 8) begin : g_chk
    $error("mtw_tlb_walk: unsupported TLB_N or IO_IDX_W");
  end

  function automatic logic [30:0] tbl_addr(input logic [22:0] ptr, input logic [7:0] idx);
    tbl_addr = {ptr, 8'h00} + {21'h0, idx, 2'h0};
  endfunction : tbl_addr

  function automatic logic [7:0] walk_idx(input logic [2:0] lv, input logic [31:0] va);
    case (lv)
      mtw_pkg::WL_L1: walk_idx = va[31:24];
      mtw_pkg::WL_L2: walk_idx = {2'h0, va[23:18]};
      mtw_pkg::WL_L3: walk_idx = {2'h0, va[17:12]};
      default:        walk_idx = 8'h00;
    endcase
  endfunction : walk_idx

  function automatic logic [30:0] form_pa(input logic [2:0] lvl, input logic [18:0] physical_frame_number,
                                          input logic [31:0] va);
    case (lvl)
      mtw_pkg::LVL_1:   form_pa = {physical_frame_number[18:12], va[23:0]};
      mtw_pkg::LVL_12:  form_pa = {physical_frame_number[18:6], va[17:0]};
      mtw_pkg::LVL_123: form_pa = {physical_frame_number, va[11:0]};
      default:          form_pa = va[30:0];
    endcase
  endfunction : form_pa

  function automatic logic [2:0] lvl_of(input logic [2:0] lv);
    case (lv)
      mtw_pkg::WL_L1: lvl_of = mtw_pkg::LVL_1;
      mtw_pkg::WL_L2: lvl_of = mtw_pkg::LVL_12;
      mtw_pkg::WL_L3: lvl_of = mtw_pkg::LVL_123;
      mtw_pkg::WL_IO: lvl_of = mtw_pkg::LVL_123;
      default:        lvl_of = mtw_pkg::LVL_NONE;
    endcase
  endfunction : lvl_of

  function automatic logic perm_ok(input logic [5:0] prot, input logic wr, input logic ex,
                                   input logic sup);
    logic [2:0] rwx;
    rwx = sup ? prot[2:0] : prot[5:3];
    perm_ok = ex ? rwx[0] : (wr ? rwx[1] : rwx[2]);
  endfunction : perm_ok

  function automatic logic tlb_match(input logic [2:0] lvl, input logic [19:0] tag,
                                     input logic [5:0] ectx, input logic esup,
                                     input logic [31:0] va, input logic [5:0] ctx);
    tlb_match = lvl[2] && (va[31:24] == tag[19:12])
                && (!lvl[1] || va[23:18] == tag[11:6])
                && (!lvl[0] || va[17:12] == tag[5:0])
                && (esup || ectx == ctx);
  endfunction : tlb_match

  mtw_pkg::mtw_state_e state_ff;
  logic        src_ff;
  logic [31:0] va_ff;
  logic        wr_ff;
  logic        ex_ff;
  logic        sup_ff;
  logic [5:0]  ctx_ff;
  logic [2:0]  lv_ff;
  logic [30:0] addr_ff;
  logic        ack_ff;
  logic [30:0] pa_ff;
  logic        iu_pf_ff;
  logic        iu_wf_ff;
  logic        dva_f_ff;
  logic [IW-1:0] victim_ff;

  logic [2:0]  t_lvl_ff  [TLB_N];
  logic [19:0] t_tag_ff  [TLB_N];
  logic [5:0]  t_ctx_ff  [TLB_N];
  logic        t_sup_ff  [TLB_N];
  logic        t_mod_ff  [TLB_N];
  logic        t_io_ff   [TLB_N];
  logic        t_ptp_ff  [TLB_N];
  logic [22:0] t_phys_ff [TLB_N];
  logic [5:0]  t_prot_ff [TLB_N];

  logic [TLB_N-1:0] m_vec;
  logic          hit_any, p2_any, p3_any, hit_ok;
  logic [IW-1:0] hit_idx, p2_idx, p3_idx;
  logic [5:0]    dec_prot;
  logic [1:0]    rd_et;

  mtw_acc_dec u_acc_dec (
    .acc_in   (mem_rdata_in[mtw_pkg::ACC_LSB +: 3]),
    .prot_out (dec_prot)
  );

  assign rd_et = mem_rdata_in[mtw_pkg::ET_LSB +: 2];

  for (genvar g = 0; g < TLB_N; g++) begin : g_match
    assign m_vec[g] = tlb_match(t_lvl_ff[g], t_tag_ff[g], t_ctx_ff[g], t_sup_ff[g], va_ff, ctx_ff)
                      && (t_io_ff[g] == src_ff);
  end

  // Lowest index wins among translations and each class of cached pointer
  always_comb begin
    hit_any = 1'b0;
    p2_any  = 1'b0;
    p3_any  = 1'b0;
    hit_idx = '0;
    p2_idx  = '0;
    p3_idx  = '0;
    for (int i = TLB_N - 1; i >= 0; i--) begin
      if (m_vec[i] && !t_ptp_ff[i]) begin
        hit_any = 1'b1;
        hit_idx = IW'(i);
      end
      if (m_vec[i] && t_ptp_ff[i] && t_lvl_ff[i] == mtw_pkg::LVL_1) begin
        p2_any = 1'b1;
        p2_idx = IW'(i);
      end
      if (m_vec[i] && t_ptp_ff[i] && t_lvl_ff[i] == mtw_pkg::LVL_12) begin
        p3_any = 1'b1;
        p3_idx = IW'(i);
      end
    end
    hit_ok = perm_ok(t_prot_ff[hit_idx], wr_ff, ex_ff, sup_ff);
  end

  logic        fin, fin_pf, fin_wf, go_walk, mod_en;
  logic [30:0] fin_pa, walk_addr;
  logic [2:0]  walk_lv;
  logic        ld_en, ld_ptp, ld_io, ld_sup, ld_mod;
  logic [2:0]  ld_lvl;
  logic [22:0] ld_phys;
  logic [5:0]  ld_prot;
  logic        pte_ok;

  always_comb begin
    fin       = 1'b0;
    fin_pf    = 1'b0;
    fin_wf    = 1'b0;
    fin_pa    = va_ff[30:0];
    go_walk   = 1'b0;
    mod_en    = 1'b0;
    walk_lv   = mtw_pkg::WL_CTX;
    walk_addr = tbl_addr(ctx_table_ptr_in, {2'h0, ctx_ff});
    ld_en     = 1'b0;
    ld_ptp    = 1'b0;
    ld_io     = 1'b0;
    ld_sup    = 1'b0;
    ld_mod    = 1'b0;
    ld_lvl    = lvl_of(lv_ff);
    ld_phys   = {4'h0, mem_rdata_in[mtw_pkg::PPN_LSB +: mtw_pkg::PPN_W]};
    ld_prot   = dec_prot;
    pte_ok    = perm_ok(dec_prot, wr_ff, ex_ff, sup_ff);
    unique case (state_ff)
      mtw_pkg::ST_IDLE: ;
      mtw_pkg::ST_LOOK: begin
        if (hit_any) begin
          fin    = 1'b1;
          fin_pa = form_pa(t_lvl_ff[hit_idx], t_phys_ff[hit_idx][18:0], va_ff);
          fin_pf = !hit_ok;
          mod_en = wr_ff && hit_ok;
        end else begin
          go_walk = 1'b1;
          if (src_ff) begin
            walk_lv   = mtw_pkg::WL_IO;
            walk_addr = tbl_addr(io_table_ptr_in, va_ff[19:12] & IO_MASK);
          end else if (p3_any) begin
            walk_lv   = mtw_pkg::WL_L3;
            walk_addr = tbl_addr(t_phys_ff[p3_idx], walk_idx(mtw_pkg::WL_L3, va_ff));
          end else if (p2_any) begin
            walk_lv   = mtw_pkg::WL_L2;
            walk_addr = tbl_addr(t_phys_ff[p2_idx], walk_idx(mtw_pkg::WL_L2, va_ff));
          end
        end
      end
      mtw_pkg::ST_MEM: begin
        if (mem_ack_in && lv_ff == mtw_pkg::WL_IO) begin
          fin = 1'b1;
          if (mem_rdata_in[mtw_pkg::IO_VALID_BIT]) begin
            ld_en   = 1'b1;
            ld_io   = 1'b1;
            ld_sup  = 1'b1;
            ld_mod  = wr_ff && mem_rdata_in[mtw_pkg::IO_WR_BIT];
            ld_prot = {1'b1, mem_rdata_in[mtw_pkg::IO_WR_BIT], 1'b0,
                       1'b1, mem_rdata_in[mtw_pkg::IO_WR_BIT], 1'b0};
            fin_pa  = {mem_rdata_in[mtw_pkg::PPN_LSB +: mtw_pkg::PPN_W], va_ff[11:0]};
            fin_pf  = wr_ff && !mem_rdata_in[mtw_pkg::IO_WR_BIT];
          end else begin
            fin_wf = 1'b1;
          end
        end else if (mem_ack_in) begin
          unique case (rd_et)
            mtw_pkg::ET_PTP: begin
              if (lv_ff == mtw_pkg::WL_L3) begin
                fin    = 1'b1;
                fin_wf = 1'b1;
              end else begin
                go_walk   = 1'b1;
                walk_lv   = lv_ff + 3'h1;
                walk_addr = tbl_addr(mem_rdata_in[mtw_pkg::PTR_LSB +: mtw_pkg::PTR_W],
                                     walk_idx(lv_ff + 3'h1, va_ff));
                ld_en     = (lv_ff != mtw_pkg::WL_CTX);
                ld_ptp    = 1'b1;
                ld_phys   = mem_rdata_in[mtw_pkg::PTR_LSB +: mtw_pkg::PTR_W];
              end
            end
            mtw_pkg::ET_PTE: begin
              fin    = 1'b1;
              fin_pa = form_pa(lvl_of(lv_ff), ld_phys[18:0], va_ff);
              fin_pf = !pte_ok;
              ld_en  = (lv_ff != mtw_pkg::WL_CTX);
              ld_sup = ~|dec_prot[5:3];
              ld_mod = mem_rdata_in[mtw_pkg::MOD_BIT] || (wr_ff && pte_ok);
            end
            mtw_pkg::ET_INVALID, mtw_pkg::ET_RSVD: begin
              fin    = 1'b1;
              fin_wf = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  // Request capture, walk sequencing and answer registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= mtw_pkg::ST_IDLE;
      src_ff   <= 1'b0;
      va_ff    <= '0;
      wr_ff    <= 1'b0;
      ex_ff    <= 1'b0;
      sup_ff   <= 1'b0;
      ctx_ff   <= '0;
      lv_ff    <= mtw_pkg::WL_CTX;
      addr_ff  <= '0;
      ack_ff   <= 1'b0;
      pa_ff    <= '0;
      iu_pf_ff <= 1'b0;
      iu_wf_ff <= 1'b0;
      dva_f_ff <= 1'b0;
    end else begin
      ack_ff   <= fin;
      iu_pf_ff <= fin && !src_ff && fin_pf;
      iu_wf_ff <= fin && !src_ff && fin_wf;
      dva_f_ff <= fin && src_ff && (fin_pf || fin_wf);
      if (fin) begin
        pa_ff <= fin_pa;
      end
      unique case (state_ff)
        mtw_pkg::ST_IDLE: begin
          // Integer unit first; the answer cycle itself takes nothing
          if (!ack_ff && (iu_req_in || dva_req_in)) begin
            src_ff   <= !iu_req_in;
            va_ff    <= iu_req_in ? iu_va_in : dva_va_in;
            wr_ff    <= iu_req_in ? iu_write_in : dva_write_in;
            ex_ff    <= iu_req_in && iu_exec_in;
            sup_ff   <= iu_req_in ? iu_super_in : 1'b1;
            ctx_ff   <= ctx_in;
            state_ff <= mtw_pkg::ST_LOOK;
          end
        end
        mtw_pkg::ST_LOOK, mtw_pkg::ST_MEM: begin
          if (fin) begin
            state_ff <= mtw_pkg::ST_IDLE;
          end else if (go_walk) begin
            addr_ff  <= walk_addr;
            lv_ff    <= walk_lv;
            state_ff <= mtw_pkg::ST_MEM;
          end
        end
      endcase
    end
  end

  // TLB storage: round-robin fill, modified marking, flush
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      victim_ff <= '0;
      for (int i = 0; i < TLB_N; i++) begin
        t_lvl_ff[i]  <= mtw_pkg::LVL_NONE;
        t_tag_ff[i]  <= '0;
        t_ctx_ff[i]  <= '0;
        t_sup_ff[i]  <= 1'b0;
        t_mod_ff[i]  <= 1'b0;
        t_io_ff[i]   <= 1'b0;
        t_ptp_ff[i]  <= 1'b0;
        t_phys_ff[i] <= '0;
        t_prot_ff[i] <= '0;
      end
    end else if (tlb_flush_in) begin
      for (int i = 0; i < TLB_N; i++) begin
        t_lvl_ff[i] <= mtw_pkg::LVL_NONE;
      end
    end else if (ld_en) begin
      victim_ff            <= victim_ff + IW'(1);
      t_lvl_ff[victim_ff]  <= ld_lvl;
      t_tag_ff[victim_ff]  <= va_ff[31:12];
      t_ctx_ff[victim_ff]  <= ctx_ff;
      t_sup_ff[victim_ff]  <= ld_sup;
      t_mod_ff[victim_ff]  <= ld_mod;
      t_io_ff[victim_ff]   <= ld_io;
      t_ptp_ff[victim_ff]  <= ld_ptp;
      t_phys_ff[victim_ff] <= ld_phys;
      t_prot_ff[victim_ff] <= ld_prot;
    end else if (mod_en) begin
      t_mod_ff[hit_idx] <= 1'b1;
    end
  end

  assign iu_ack_out        = ack_ff && !src_ff;
  assign dva_ack_out       = ack_ff && src_ff;
  assign iu_pa_out         = pa_ff;
  assign dva_pa_out        = pa_ff[mtw_pkg::SBA_W-1:0];
  assign iu_prot_fault_out = iu_pf_ff;
  assign iu_walk_fault_out = iu_wf_ff;
  assign dva_fault_out     = dva_f_ff;
  assign mem_req_out       = (state_ff == mtw_pkg::ST_MEM);
  assign mem_addr_out      = addr_ff;
  assign walk_busy_out     = (state_ff == mtw_pkg::ST_MEM);

  property p_bad_et;
    @(posedge clk_in) disable iff (rst_in)
    (mem_req_out && mem_ack_in && lv_ff != mtw_pkg::WL_IO && !src_ff && rd_et[0] == rd_et[1])
    |=> iu_ack_out && iu_walk_fault_out && !mem_req_out;
  endproperty
  a_bad_et: assert property (p_bad_et) else $error("bad entry type did not fault");

  property p_ptp_next;
    @(posedge clk_in) disable iff (rst_in)
    (mem_req_out && mem_ack_in && lv_ff == mtw_pkg::WL_L1 && rd_et == mtw_pkg::ET_PTP)
    |=> mem_req_out && lv_ff == mtw_pkg::WL_L2 && mem_addr_out[30:8] == $past(mem_rdata_in[26:4]);
  endproperty
  a_ptp_next: assert property (p_ptp_next) else $error("pointer did not advance walk");

  property p_pte_stop;
    @(posedge clk_in) disable iff (rst_in)
    (mem_req_out && mem_ack_in && lv_ff != mtw_pkg::WL_IO && rd_et == mtw_pkg::ET_PTE)
    |=> ack_ff && !mem_req_out ##1 !ack_ff;
  endproperty
  a_pte_stop: assert property (p_pte_stop) else $error("walk did not stop on translation");

  property p_offset;
    @(posedge clk_in) disable iff (rst_in)
    iu_ack_out && !iu_walk_fault_out |-> iu_pa_out[11:0] == va_ff[11:0];
  endproperty
  a_offset: assert property (p_offset) else $error("page offset altered");

  property p_l2_pa;
    @(posedge clk_in) disable iff (rst_in)
    (mem_req_out && mem_ack_in && lv_ff == mtw_pkg::WL_L2 && rd_et == mtw_pkg::ET_PTE)
    |=> pa_ff[17:0] == va_ff[17:0] && pa_ff[30:18] == $past(mem_rdata_in[26:14]);
  endproperty
  a_l2_pa: assert property (p_l2_pa) else $error("level 2 address wrong");

  property p_io_pa;
    @(posedge clk_in) disable iff (rst_in)
    (mem_req_out && mem_ack_in && lv_ff == mtw_pkg::WL_IO && mem_rdata_in[1])
    |=> dva_ack_out && pa_ff[30:12] == $past(mem_rdata_in[26:8]);
  endproperty
  a_io_pa: assert property (p_io_pa) else $error("I/O frame number wrong");

  property p_io_check;
    @(posedge clk_in) disable iff (rst_in)
    (mem_req_out && mem_ack_in && lv_ff == mtw_pkg::WL_IO && (!mem_rdata_in[1] || (wr_ff && !mem_rdata_in[2])))
    |=> dva_ack_out && dva_fault_out;
  endproperty
  a_io_check: assert property (p_io_check) else $error("I/O entry check missed");

  property p_hit_fast;
    @(posedge clk_in) disable iff (rst_in)
    state_ff == mtw_pkg::ST_LOOK && hit_any |=> ack_ff && !mem_req_out;
  endproperty
  a_hit_fast: assert property (p_hit_fast) else $error("hit did not answer in one cycle");

  property p_user_none;
    @(posedge clk_in) disable iff (rst_in)
    (mem_req_out && mem_ack_in && !src_ff && !sup_ff && lv_ff != mtw_pkg::WL_IO &&
     rd_et == mtw_pkg::ET_PTE && mem_rdata_in[4:3] == 2'h3)
    |=> iu_prot_fault_out;
  endproperty
  a_user_none: assert property (p_user_none) else $error("user access not refused");

  property p_mod_set;
    @(posedge clk_in) disable iff (rst_in)
    mod_en && !tlb_flush_in |=> t_mod_ff[$past(hit_idx)];
  endproperty
  a_mod_set: assert property (p_mod_set) else $error("modified bit not set");

  c_hit: cover property (@(posedge clk_in) disable iff (rst_in) state_ff == mtw_pkg::ST_LOOK && hit_any);
  c_walk3: cover property (@(posedge clk_in) disable iff (rst_in)
    mem_req_out && mem_ack_in && lv_ff == mtw_pkg::WL_L3 && rd_et == mtw_pkg::ET_PTE);
  c_dva: cover property (@(posedge clk_in) disable iff (rst_in) dva_ack_out && !dva_fault_out);
endmodule : mtw_tlb_walk

/* test_mtw_tlb_walk.sv */
`timescale 1ns/1ps
module test_mtw_tlb_walk;
  logic        clk_in = 1'b0, rst_in = 1'b1;
  logic        iu_req_in = 1'b0, iu_write_in = 1'b0, iu_super_in = 1'b0;
  logic        dva_req_in = 1'b0, dva_write_in = 1'b0;
  logic        tlb_flush_in = 1'b0, iu_exec_in = 1'b0, walk_busy_out;
  logic [5:0]  ctx_in = 6'h01;
  logic [31:0] iu_va_in = 32'h0000_0000, dva_va_in = 32'h0000_0000;
  logic        iu_ack_out, iu_prot_fault_out, iu_walk_fault_out, dva_ack_out, dva_fault_out;
  logic        mem_req_out, mem_ack_in;
  logic [30:0] iu_pa_out, mem_addr_out;
  logic [27:0] dva_pa_out;
  logic [31:0] mem_rdata_in;
  int          n_errors = 0, n_compared = 0;
  mtw_tlb_walk #(.TLB_N(8), .IO_IDX_W(8)) dut (.clk_in, .rst_in, .ctx_in,
    .ctx_table_ptr_in(23'h00_0010), .io_table_ptr_in(23'h00_0050), .tlb_flush_in,
    .iu_req_in, .iu_va_in, .iu_write_in, .iu_exec_in, .iu_super_in, .iu_ack_out,
    .iu_pa_out, .iu_prot_fault_out, .iu_walk_fault_out, .dva_req_in, .dva_va_in,
    .dva_write_in, .dva_ack_out, .dva_pa_out, .dva_fault_out, .mem_req_out,
    .mem_addr_out, .mem_ack_in, .mem_rdata_in, .walk_busy_out);
  mtw_mem_model mem_u (.clk_in, .req_in(mem_req_out), .addr_in(mem_addr_out),
    .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
  initial forever #2.5 clk_in = ~clk_in;
  task automatic close_out();
    $display("Compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // All ones in pa skips the address check, rd below zero the read count
  task automatic op(input logic dva, input logic [31:0] va, input logic wr, input logic sup,
                    input logic [31:0] pa, input logic [1:0] flt, input int rd);
    int n0;
    int i;
    int nb;
    n0 = mem_u.n_rd;
    nb = 0;
    @(posedge clk_in);
    #1;
    iu_req_in = !dva;
    dva_req_in = dva;
    iu_va_in = va;
    dva_va_in = va;
    iu_write_in = wr;
    dva_write_in = wr;
    iu_super_in = sup;
    for (i = 0; i < 300; i++) begin
      @(posedge clk_in);
      #1;
      if (walk_busy_out === 1'b1) nb++;
      if ((dva ? dva_ack_out : iu_ack_out) === 1'b1) break;
    end
    iu_req_in = 1'b0;
    dva_req_in = 1'b0;
    if (i == 300) begin
      n_errors++;
      close_out();
    end
    if (pa !== 32'hFFFF_FFFF) cmp("pa", pa, dva ? {4'h0, dva_pa_out} : {1'b0, iu_pa_out});
    cmp("fault", {30'h0, flt}, dva ? {31'h0, dva_fault_out} : {30'h0, iu_prot_fault_out, iu_walk_fault_out});
    if (rd >= 0) cmp("reads", rd, mem_u.n_rd - n0);
    if (rd >= 0) cmp("busy", {31'h0, rd > 0}, {31'h0, nb > 0});
  endtask : op
  task automatic t_walk3();
    op(0, 32'h0140_5123, 0, 1, 32'h1234_5123, 2'b00, 4);
    op(0, 32'h0140_5FFC, 1, 0, 32'h1234_5FFC, 2'b00, 0);
  endtask : t_walk3
  task automatic t_prot();
    op(0, 32'h0140_6008, 1, 1, 32'h0077_7008, 2'b10, 1);
    op(0, 32'h0140_7010, 0, 0, 32'h0011_1010, 2'b10, 1);
    op(0, 32'h0140_7010, 0, 1, 32'h0011_1010, 2'b00, 0);
  endtask : t_prot
  task automatic t_fault();
    mem_u.wait_n = 3;
    op(0, 32'h0180_0ABC, 0, 1, 32'h7FFC_0ABC, 2'b00, 1);
    op(0, 32'h0240_0000, 0, 1, 32'hFFFF_FFFF, 2'b01, 2);
    op(0, 32'h0300_0000, 0, 1, 32'hFFFF_FFFF, 2'b01, 2);
    mem_u.wait_n = 0;
  endtask : t_fault
  task automatic t_dva();
    op(1, 32'h0000_3456, 0, 1, 32'h00AB_C456, 2'b00, 1);
    op(1, 32'h0000_3456, 1, 1, 32'hFFFF_FFFF, 2'b01, -1);
    op(1, 32'h0000_4000, 0, 1, 32'hFFFF_FFFF, 2'b01, 1);
  endtask : t_dva
  // Context, execute rights, three more permission codes, then flush
  task automatic t_exec();
    ctx_in = 6'h02;
    op(0, 32'h0140_5123, 0, 1, 32'hFFFF_FFFF, 2'b01, 1);
    op(0, 32'h0140_7010, 0, 1, 32'h0011_1010, 2'b00, 0);
    ctx_in = 6'h01;
    op(0, 32'h0140_8010, 0, 0, 32'h0022_2010, 2'b00, 1);
    iu_exec_in = 1'b1;
    op(0, 32'h0140_8010, 0, 0, 32'h0022_2010, 2'b10, 0);
    op(0, 32'h0140_8010, 0, 1, 32'h0022_2010, 2'b00, 0);
    op(0, 32'h0140_6008, 0, 1, 32'h0077_7008, 2'b10, 0);
    op(0, 32'h0140_9000, 0, 1, 32'h0033_3000, 2'b00, 1);
    iu_exec_in = 1'b0;
    op(0, 32'h0140_9000, 0, 1, 32'h0033_3000, 2'b10, 0);
    op(0, 32'h0140_A000, 1, 1, 32'h0044_4000, 2'b00, 1);
    tlb_flush_in = 1'b1;
    @(posedge clk_in);
    #1;
    tlb_flush_in = 1'b0;
    op(0, 32'h0140_5123, 0, 1, 32'h1234_5123, 2'b00, 4);
  endtask : t_exec
  initial begin
    mem_u.mem[32'h0000_1004] = 32'h0000_0201;
    mem_u.mem[32'h0000_2004] = 32'h0000_0301;
    mem_u.mem[32'h0000_200C] = 32'h0000_0003;
    mem_u.mem[32'h0000_3040] = 32'h0000_0401;
    mem_u.mem[32'h0000_3080] = 32'h07FF_C006;
    mem_u.mem[32'h0000_4014] = 32'h0123_450E;
    mem_u.mem[32'h0000_4018] = 32'h0007_7702;
    mem_u.mem[32'h0000_401C] = 32'h0001_111A;
    mem_u.mem[32'h0000_4020] = 32'h0002_2216;
    mem_u.mem[32'h0000_4024] = 32'h0003_3312;
    mem_u.mem[32'h0000_4028] = 32'h0004_441E;
    mem_u.mem[32'h0000_500C] = 32'h000A_BC02;
    repeat (4) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    t_walk3();
    t_prot();
    t_fault();
    t_dva();
    t_exec();
    close_out();
  end
endmodule : test_mtw_tlb_walk
